// file: rtl/lsmpc_pkg.sv
package lsmpc_pkg;

    // ******************************************************************
    // Clock and timing
    // ******************************************************************
    localparam int CLK_PERIOD_NS       = 40;
    localparam int KEEPALIVE_NS        = 310000000;
    localparam int KEEPALIVE_CYC       = KEEPALIVE_NS / CLK_PERIOD_NS;
    localparam int CAL_MIN_NS          = 3000000;
    localparam int CAL_MIN_CYC         =
        (CAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_MAX_NS          = 7000000;
    localparam int CAL_MAX_CYC         = CAL_MAX_NS / CLK_PERIOD_NS;
    localparam int EXT_MIN_NS          = 15000;
    localparam int EXT_MIN_CYC         =
        (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_MAX_NS          = 100000;
    localparam int EXT_MAX_CYC         = EXT_MAX_NS / CLK_PERIOD_NS;
    localparam int INT_PER_NS          = 39000;
    localparam logic [10:0] INT_PER_RST =
        11'(INT_PER_NS / CLK_PERIOD_NS);

    // ******************************************************************
    // Serial word layout
    // ******************************************************************
    localparam logic [4:0] SPI_BITS    = 5'h10;
    localparam int WORD_KEEPALIVE      = 15;
    localparam int WORD_ADDR_MSB       = 14;
    localparam int WORD_ADDR_LSB       = 11;
    localparam int WORD_EXIT           = 0;
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_CH0    = 4'h1;
    localparam logic [3:0] ADDR_CAL    = 4'h5;
    localparam logic [3:0] ADDR_MISC   = 4'h6;
    localparam logic [10:0] CAL_WORD   = 11'h5a5;
    localparam int CTRL_ON_LSB         = 0;
    localparam int CTRL_DIRDIS_LSB     = 4;
    localparam int CTRL_PWM_EN         = 8;
    localparam int CTRL_CLK_SEL        = 9;
    localparam int CTRL_HIGH_BATTERY_SHUTDOWN_OFF         = 10;
    localparam int MISC_VDD_EN         = 0;
    localparam int CH_DUTY_LSB         = 0;
    localparam int CH_DELAY_LSB        = 7;
    localparam logic [6:0] DUTY_FULL   = 7'h7f;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {
        LSMPC_SLEEP    = 2'b00,
        LSMPC_NORMAL   = 2'b01,
        LSMPC_FAILSAFE = 2'b11,
        LSMPC_FAULT    = 2'b10
    } lsmpc_mode_t;

    typedef struct packed {
        logic [6:0] duty;
        logic [2:0] delay;
    } lsmpc_chan_t;

    typedef struct packed {
        logic [3:0] lamp_req;
        logic       wake;
        logic       reset_wake;
        logic       cs_n;
        logic       sclk;
        logic       si;
        logic       failsafe_config_pin;
        logic       vdd_fail;
        logic [3:0] overcurrent_flag;
        logic [3:0] overheat_flag;
        logic [3:0] severe_short_flag;
        logic       undervoltage_flag;
        logic       high_battery_flag;
    } lsmpc_pins_t;

endpackage

// file: rtl/lsmpc_core.sv
`timescale 1ns/10ps
// Contract
// - Serial words are 16 bits, MSB first, full duplex.
// - Wake-up is reset_wake OR wake OR any direct lamp request.
// - Fail when supply loss enabled, or keepalive timeout with config pin open.
// - Fault from any channel flag, undervoltage, or high battery with shutdown off.
// - Wake-up low selects sleep; all outputs off.
// - Decode normal, fail-safe, fault from wake, fail, fault.
// - In sleep all serial settings act as zero.
// - Normal drive is direct-or-switch, or switch AND duty wave.
// - Rearm command is switch bit, or unblocked direct request without PWM.
// - PWM drives a channel only with module enable and switch bit.
// - PWM period is 128 selected clock ticks.
// - Duty code n is high n+1 of 128; all ones full on.
// - Switching delayed by delay code times 16 ticks.
// - External clock out of range stops PWM, switch bits drive, flag set.
// - Calibration word then chip-select low pulse sets period pulse/128.
// - Out-of-window calibration pulse ignored, previous period kept.
// - Clock source bit selects internal oscillator for PWM.
// - Keepalive starts on rising wake, request or reset_wake with pin open.
// - Host must toggle bit 15 within the keepalive timeout.
// - Fail-safe: outputs follow direct pins, settings default except supply-loss enable, flag reads 0.
// - Exit fail-safe by exit bit with supply good; entry clears faults.
// - Config pin low ends a keepalive-caused fail-safe.
// - Sample on falling serial clock, shift out on rising, release when deselected.
// - Load status at select fall, commit data at select rise.
// - Latched faults reported serially and cleared by the valid read.
module lsmpc_core #(
    parameter int unsigned KEEPALIVE_CYC = lsmpc_pkg::KEEPALIVE_CYC,
    parameter int unsigned CAL_MIN_CYC   = lsmpc_pkg::CAL_MIN_CYC,
    parameter int unsigned CAL_MAX_CYC   = lsmpc_pkg::CAL_MAX_CYC
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    // Pins from the outside world
    input  wire lsmpc_pkg::lsmpc_pins_t pins,
    // Serial output
    output logic                      so,
    output logic                      so_oe_n,
    // Output stage commands
    output logic [3:0]                output_drive_cmd,
    output logic [3:0]                fault_rearm_cmd,
    output logic                      fault_pin_oe_n,
    // Status
    output lsmpc_pkg::lsmpc_mode_t    mode,
    output logic                      ext_clock_lost
);

    // ******************************************************************
    // Synchroniser
    // ******************************************************************
    lsmpc_pkg::lsmpc_pins_t s1_q, s2_q, s3_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (clk_en) begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic cs_fall, cs_rise, sck_fall, sck_rise, ext_tick, wake_rise;
    assign cs_fall   = s3_q.cs_n & ~s2_q.cs_n;
    assign cs_rise   = ~s3_q.cs_n & s2_q.cs_n;
    assign sck_fall  = ~s2_q.cs_n & s3_q.sclk & ~s2_q.sclk;
    assign sck_rise  = ~s2_q.cs_n & ~s3_q.sclk & s2_q.sclk;
    assign ext_tick  = s2_q.lamp_req[0] & ~s3_q.lamp_req[0];
    assign wake_rise = |({s2_q.wake, s2_q.reset_wake, s2_q.lamp_req}
                       & ~{s3_q.wake, s3_q.reset_wake, s3_q.lamp_req});

    // ******************************************************************
    // Mode decoder
    // ******************************************************************
    lsmpc_pkg::lsmpc_mode_t mode_q, mode_d;
    logic fail_q, fail_d, fail_wd_q, fail_wd_d, wd_to_q;
    logic vdd_en_q, high_battery_shutdown_off_q, commit, exit_req;
    logic wake_w, fault_w;
    logic [15:0] word;

    assign wake_w  = s2_q.reset_wake | s2_q.wake | (|s2_q.lamp_req);
    assign fault_w = (|s2_q.overcurrent_flag) | (|s2_q.overheat_flag)
                   | (|s2_q.severe_short_flag) | s2_q.undervoltage_flag
                   | (s2_q.high_battery_flag & high_battery_shutdown_off_q);
    assign exit_req = commit && mode_q == lsmpc_pkg::LSMPC_FAILSAFE
                   && word[lsmpc_pkg::WORD_EXIT] && !s2_q.vdd_fail;

    always_comb begin
        fail_wd_d = fail_wd_q;
        if (exit_req || !s2_q.failsafe_config_pin)
            fail_wd_d = 1'b0;
        if (wd_to_q && s2_q.failsafe_config_pin)
            fail_wd_d = 1'b1;
        fail_d = fail_q;
        if (exit_req || (fail_wd_q && !fail_wd_d && !s2_q.vdd_fail))
            fail_d = 1'b0;
        if ((s2_q.vdd_fail && vdd_en_q)
            || (wd_to_q && s2_q.failsafe_config_pin))
            fail_d = 1'b1;
        if (!wake_w)
            mode_d = lsmpc_pkg::LSMPC_SLEEP;
        else if (fault_w)
            mode_d = lsmpc_pkg::LSMPC_FAULT;
        else if (fail_q)
            mode_d = lsmpc_pkg::LSMPC_FAILSAFE;
        else
            mode_d = lsmpc_pkg::LSMPC_NORMAL;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q    <= lsmpc_pkg::LSMPC_SLEEP;
            fail_q    <= 1'b0;
            fail_wd_q <= 1'b0;
        end else if (clk_en) begin
            mode_q    <= mode_d;
            fail_q    <= fail_d;
            fail_wd_q <= fail_wd_d;
        end
    end

    // ******************************************************************
    // Serial shifter
    // ******************************************************************
    logic [15:0] sh_q, sh_d, status_w;
    logic [4:0]  cnt_q, cnt_d;
    logic        so_q, so_d, pup_q, pup_d;
    logic [9:0]  st_q, st_d, rep_q, rep_d;
    logic        lost_q;

    assign word   = sh_q;
    assign commit = cs_rise && cnt_q == lsmpc_pkg::SPI_BITS;
    assign status_w = {mode_q == lsmpc_pkg::LSMPC_NORMAL, lost_q, pup_q,
                       3'h0, st_q};

    always_comb begin
        sh_d  = sh_q;
        cnt_d = cnt_q;
        so_d  = so_q;
        rep_d = rep_q;
        pup_d = pup_q;
        st_d  = st_q;
        if (cs_fall) begin
            sh_d  = status_w;
            so_d  = status_w[15];
            cnt_d = '0;
            rep_d = st_q;
        end else if (sck_fall) begin
            sh_d = {sh_q[14:0], s2_q.si};
            if (cnt_q != 5'h1f)
                cnt_d = cnt_q + 5'h01;
        end else if (sck_rise) begin
            so_d = sh_q[15];
        end
        if (commit) begin
            st_d  = st_q & ~rep_q;
            pup_d = 1'b0;
        end
        if (mode_q != mode_d && (mode_d == lsmpc_pkg::LSMPC_NORMAL
            || mode_d == lsmpc_pkg::LSMPC_FAILSAFE))
            st_d = '0;
        st_d = st_d | {s2_q.undervoltage_flag, s2_q.high_battery_flag,
                       s2_q.overcurrent_flag | s2_q.severe_short_flag,
                       s2_q.overheat_flag};
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sh_q  <= '0;
            cnt_q <= '0;
            so_q  <= 1'b0;
            rep_q <= '0;
            st_q  <= '0;
            pup_q <= 1'b1;
        end else if (clk_en) begin
            sh_q  <= sh_d;
            cnt_q <= cnt_d;
            so_q  <= so_d;
            rep_q <= rep_d;
            st_q  <= st_d;
            pup_q <= pup_d;
        end
    end

    // ******************************************************************
    // Settings
    // ******************************************************************
    logic [3:0] on_q, on_d, dis_q, dis_d;
    logic pwm_en_q, pwm_en_d, sel_q, sel_d, high_battery_shutdown_off_d, vdd_en_d;
    lsmpc_pkg::lsmpc_chan_t ch_q [4];
    lsmpc_pkg::lsmpc_chan_t ch_d [4];
    logic [3:0] addr;

    assign addr = word[lsmpc_pkg::WORD_ADDR_MSB:lsmpc_pkg::WORD_ADDR_LSB];

    always_comb begin
        on_d     = on_q;
        dis_d    = dis_q;
        pwm_en_d = pwm_en_q;
        sel_d    = sel_q;
        high_battery_shutdown_off_d = high_battery_shutdown_off_q;
        vdd_en_d = vdd_en_q;
        ch_d     = ch_q;
        if (commit && mode_q != lsmpc_pkg::LSMPC_FAILSAFE) begin
            if (addr == lsmpc_pkg::ADDR_CTRL) begin
                on_d     = word[lsmpc_pkg::CTRL_ON_LSB +: 4];
                dis_d    = word[lsmpc_pkg::CTRL_DIRDIS_LSB +: 4];
                pwm_en_d = word[lsmpc_pkg::CTRL_PWM_EN];
                sel_d    = word[lsmpc_pkg::CTRL_CLK_SEL];
                high_battery_shutdown_off_d = word[lsmpc_pkg::CTRL_HIGH_BATTERY_SHUTDOWN_OFF];
            end
            if (addr == lsmpc_pkg::ADDR_MISC)
                vdd_en_d = word[lsmpc_pkg::MISC_VDD_EN];
            for (int i = 0; i < 4; i++) begin
                if (addr == lsmpc_pkg::ADDR_CH0 + 4'(i)) begin
                    ch_d[i].duty  = word[lsmpc_pkg::CH_DUTY_LSB +: 7];
                    ch_d[i].delay = word[lsmpc_pkg::CH_DELAY_LSB +: 3];
                end
            end
        end
        if (mode_q == lsmpc_pkg::LSMPC_SLEEP
            || mode_q == lsmpc_pkg::LSMPC_FAILSAFE) begin
            on_d     = '0;
            dis_d    = '0;
            pwm_en_d = 1'b0;
            sel_d    = 1'b0;
            high_battery_shutdown_off_d = 1'b0;
            if (mode_q == lsmpc_pkg::LSMPC_SLEEP)
                vdd_en_d = 1'b0;
            for (int i = 0; i < 4; i++)
                ch_d[i] = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            on_q     <= '0;
            dis_q    <= '0;
            pwm_en_q <= 1'b0;
            sel_q    <= 1'b0;
            high_battery_shutdown_off_q <= 1'b0;
            vdd_en_q <= 1'b0;
            for (int i = 0; i < 4; i++)
                ch_q[i] <= '0;
        end else if (clk_en) begin
            on_q     <= on_d;
            dis_q    <= dis_d;
            pwm_en_q <= pwm_en_d;
            sel_q    <= sel_d;
            high_battery_shutdown_off_q <= high_battery_shutdown_off_d;
            vdd_en_q <= vdd_en_d;
            ch_q     <= ch_d;
        end
    end

    // ******************************************************************
    // Keepalive, calibration and PWM clocks
    // ******************************************************************
    // The supply-loss enable survives fail-safe so that the loss can be
    // seen to clear; every other setting returns to default there.
    logic        wd_run_q, wd_run_d, wd_last_q, wd_last_d, wd_to_d;
    logic [23:0] wd_cnt_q, wd_cnt_d;
    logic        arm_q, arm_d, meas_q, meas_d, lost_d, int_tick, tick;
    logic [17:0] cal_q, cal_d;
    logic [10:0] per_q, per_d, div_q, div_d;
    logic [11:0] mon_q, mon_d;
    logic [6:0]  pwm_q, pwm_d;

    assign int_tick = div_q == per_q - 11'h001;
    assign tick     = sel_q ? int_tick : ext_tick;

    always_comb begin
        wd_run_d  = wd_run_q;
        wd_cnt_d  = wd_cnt_q;
        wd_last_d = wd_last_q;
        wd_to_d   = 1'b0;
        if (wake_rise && s2_q.failsafe_config_pin)
            wd_run_d = 1'b1;
        if (commit && word[lsmpc_pkg::WORD_KEEPALIVE] != wd_last_q) begin
            wd_last_d = word[lsmpc_pkg::WORD_KEEPALIVE];
            wd_cnt_d  = '0;
        end else if (wd_run_q && mode_q == lsmpc_pkg::LSMPC_NORMAL) begin
            if (32'(wd_cnt_q) >= KEEPALIVE_CYC - 1) begin
                wd_to_d  = 1'b1;
                wd_cnt_d = '0;
            end else begin
                wd_cnt_d = wd_cnt_q + 24'h000001;
            end
        end
        if (!s2_q.failsafe_config_pin || mode_q == lsmpc_pkg::LSMPC_SLEEP)
            wd_run_d = 1'b0;
        arm_d  = arm_q;
        meas_d = meas_q;
        cal_d  = cal_q;
        per_d  = per_q;
        if (commit && addr == lsmpc_pkg::ADDR_CAL
            && word[10:0] == lsmpc_pkg::CAL_WORD)
            arm_d = 1'b1;
        if (cs_fall && arm_q) begin
            meas_d = 1'b1;
            cal_d  = '0;
        end else if (meas_q && !cs_rise && cal_q != 18'h3ffff) begin
            cal_d = cal_q + 18'h00001;
        end
        if (cs_rise && meas_q) begin
            meas_d = 1'b0;
            arm_d  = 1'b0;
            if (32'(cal_q) >= CAL_MIN_CYC && 32'(cal_q) <= CAL_MAX_CYC)
                per_d = cal_q[17:7];
        end
        div_d = int_tick ? 11'h000 : div_q + 11'h001;
        mon_d = ext_tick ? 12'h000
              : (mon_q == 12'(lsmpc_pkg::EXT_MAX_CYC) ? mon_q
                 : mon_q + 12'h001);
        lost_d = lost_q;
        if (ext_tick)
            lost_d = mon_q < 12'(lsmpc_pkg::EXT_MIN_CYC);
        else if (mon_q == 12'(lsmpc_pkg::EXT_MAX_CYC))
            lost_d = 1'b1;
        pwm_d = tick ? pwm_q + 7'h01 : pwm_q;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wd_run_q  <= 1'b0;
            wd_cnt_q  <= '0;
            wd_last_q <= 1'b0;
            wd_to_q   <= 1'b0;
            arm_q     <= 1'b0;
            meas_q    <= 1'b0;
            cal_q     <= '0;
            per_q     <= lsmpc_pkg::INT_PER_RST;
            div_q     <= '0;
            mon_q     <= '0;
            lost_q    <= 1'b0;
            pwm_q     <= '0;
        end else if (clk_en) begin
            wd_run_q  <= wd_run_d;
            wd_cnt_q  <= wd_cnt_d;
            wd_last_q <= wd_last_d;
            wd_to_q   <= wd_to_d;
            arm_q     <= arm_d;
            meas_q    <= meas_d;
            cal_q     <= cal_d;
            per_q     <= per_d;
            div_q     <= div_d;
            mon_q     <= mon_d;
            lost_q    <= lost_d;
            pwm_q     <= pwm_d;
        end
    end

    // ******************************************************************
    // Output equations
    // ******************************************************************
    logic [3:0] drv_q, drv_d, rearm_q, rearm_d, wave, direct;
    logic       fpin_q, so_oe_q, pwm_live, clk_bad;

    assign clk_bad  = lost_q & ~sel_q;
    assign pwm_live = pwm_en_q & ~clk_bad;
    assign direct   = s2_q.lamp_req & ~dis_q;

    for (genvar g = 0; g < 4; g++) begin : g_chan
        logic [6:0] phase;
        assign phase = pwm_q - {ch_q[g].delay, 4'h0};
        assign wave[g] = ch_q[g].duty == lsmpc_pkg::DUTY_FULL
                       || phase <= ch_q[g].duty;
    end

    always_comb begin
        case (mode_q)
            lsmpc_pkg::LSMPC_NORMAL, lsmpc_pkg::LSMPC_FAULT: begin
                if (pwm_live)
                    drv_d = on_q & wave;
                else if (pwm_en_q)
                    drv_d = on_q;
                else
                    drv_d = direct | on_q;
                rearm_d = on_q | (pwm_en_q ? 4'h0 : direct);
            end
            lsmpc_pkg::LSMPC_FAILSAFE: begin
                drv_d   = s2_q.lamp_req;
                rearm_d = on_q | (pwm_en_q ? 4'h0 : direct);
            end
            default: begin
                drv_d   = '0;
                rearm_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drv_q   <= '0;
            rearm_q <= '0;
            fpin_q  <= 1'b1;
            so_oe_q <= 1'b1;
        end else if (clk_en) begin
            drv_q   <= drv_d;
            rearm_q <= rearm_d;
            fpin_q  <= mode_d != lsmpc_pkg::LSMPC_FAULT;
            so_oe_q <= s2_q.cs_n;
        end
    end

    assign so               = so_q;
    assign so_oe_n          = so_oe_q;
    assign output_drive_cmd = drv_q;
    assign fault_rearm_cmd  = rearm_q;
    assign fault_pin_oe_n   = fpin_q;
    assign mode             = mode_q;
    assign ext_clock_lost   = lost_q;

    // ******************************************************************
    // Checks
    // ******************************************************************
    sequence s_short_frame;
        clk_en && cs_rise && cnt_q != lsmpc_pkg::SPI_BITS
        && mode_q == lsmpc_pkg::LSMPC_NORMAL;
    endsequence

    a_short_frame_ignored: assert property (@(posedge clk_sys)
        disable iff (!reset_n) s_short_frame |=> $stable(on_q) || !clk_en)
        else $error("short frame changed settings");
    a_sleep_drive_off: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && !wake_w ##1 clk_en
        |-> mode_q == lsmpc_pkg::LSMPC_SLEEP ##1 drv_q == 4'h0)
        else $error("sleep did not turn outputs off");
    a_fault_mode_entry: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && wake_w && fault_w
        |=> mode_q == lsmpc_pkg::LSMPC_FAULT)
        else $error("fault term did not select fault mode");
    a_sleep_settings_zero: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && mode_q == lsmpc_pkg::LSMPC_SLEEP
        |=> on_q == 4'h0 && !pwm_en_q)
        else $error("settings kept in sleep");
    a_pwm_period_wrap: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && tick && pwm_q == 7'h7f
        |=> pwm_q == 7'h00)
        else $error("pwm period not 128 ticks");
    a_lost_clock_drive: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && pwm_en_q && clk_bad
        && mode_q == lsmpc_pkg::LSMPC_NORMAL |=> drv_q == $past(on_q))
        else $error("lost clock did not hand outputs to switch bits");
    a_keepalive_fail: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && wd_to_q
        && s2_q.failsafe_config_pin |=> fail_q)
        else $error("timeout did not raise fail");
    a_failsafe_direct: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en
        && mode_q == lsmpc_pkg::LSMPC_FAILSAFE
        |=> drv_q == $past(s2_q.lamp_req))
        else $error("fail-safe outputs do not follow pins");
    a_status_load: assert property (@(posedge clk_sys)
        disable iff (!reset_n) clk_en && cs_fall |=> sh_q == $past(status_w))
        else $error("status not loaded at select fall");

endmodule

// file: verif/lsmpc_host.sv
`timescale 1ns/10ps
module lsmpc_host (
    // Serial lines toward the device
    output logic cs_n,
    output logic sclk,
    output logic si
);
    logic kt = 1'b0;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // Eight system clocks per serial phase, twice the oversampling floor.
    task automatic xfer(input logic [14:0] body);
        logic [15:0] w;
        kt = ~kt;
        w = {kt, body};
        cs_n = 1'b0;
        #640;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b1;
            #160 si = w[i];
            #160 sclk = 1'b0;
            #320;
        end
        si = 1'b0;
        cs_n = 1'b1;
        #640;
    endtask
endmodule

// file: verif/lamp_switch_mode_pwm_control_tb.sv
`timescale 1ns/10ps
module lamp_switch_mode_pwm_control_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic cs_n, sclk, si, so, so_oe_n, fp_oe_n, lost;
    logic [3:0] drv, rearm;
    lsmpc_pkg::lsmpc_pins_t p, pins;
    lsmpc_pkg::lsmpc_mode_t mode;
    lsmpc_pkg::lsmpc_mode_t exp_q[$];
    int err_count = 0, n_compared = 0, cyc = 0, seed = 32'hb13596a0;
    initial forever #20 clk_sys = ~clk_sys;
    always_comb begin
        pins = p;
        pins.cs_n = cs_n;
        pins.sclk = sclk;
        pins.si = si;
    end
    lsmpc_host lsmpc_host_inst (.cs_n(cs_n), .sclk(sclk), .si(si));
    lsmpc_core #(.KEEPALIVE_CYC(200), .CAL_MIN_CYC(256), .CAL_MAX_CYC(2000))
    lsmpc_core_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .pins(pins), .so(so), .so_oe_n(so_oe_n), .output_drive_cmd(drv),
        .fault_rearm_cmd(rearm), .fault_pin_oe_n(fp_oe_n), .mode(mode),
        .ext_clock_lost(lost));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Each mode change must match the oldest note left by the driver.
    always @(mode) if (reset_n === 1'b1) begin
        if (exp_q.size() == 0) check(8'(mode), 8'hff);
        else check(8'(mode), 8'(exp_q.pop_front()));
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end
    task automatic expect_mode(input lsmpc_pkg::lsmpc_mode_t m);
        exp_q.push_back(m);
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(negedge clk_sys);
        if (exp_q.size() != 0) begin
            check(8'(exp_q.size()), 8'h00);
            exp_q.delete();
        end
        repeat (6) @(negedge clk_sys);
    endtask
    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial begin
        p = '0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(8'(mode), 8'(lsmpc_pkg::LSMPC_SLEEP));
        check(8'(so_oe_n), 8'h01);
        p.wake = 1'b1;
        expect_mode(lsmpc_pkg::LSMPC_NORMAL);
        for (int i = 0; i < 4; i++) begin
            p.lamp_req = 4'($random(seed));
            repeat (6) @(negedge clk_sys);
            check(8'(drv), 8'(p.lamp_req));
            check(8'(rearm), 8'(p.lamp_req));
        end
        lsmpc_host_inst.xfer({4'h0, 11'h0f5});
        p.lamp_req = 4'($random(seed));
        repeat (6) @(negedge clk_sys);
        check(8'(drv), 8'h05);
        p.overheat_flag = 4'h4;
        expect_mode(lsmpc_pkg::LSMPC_FAULT);
        check(8'(fp_oe_n), 8'h00);
        p.overheat_flag = 4'h0;
        expect_mode(lsmpc_pkg::LSMPC_NORMAL);
        check(8'(fp_oe_n), 8'h01);
        lsmpc_host_inst.xfer({4'h6, 11'h001});
        p.vdd_fail = 1'b1;
        expect_mode(lsmpc_pkg::LSMPC_FAILSAFE);
        p.lamp_req = 4'ha;
        repeat (6) @(negedge clk_sys);
        check(8'(drv), 8'h0a);
        p.vdd_fail = 1'b0;
        exp_q.push_back(lsmpc_pkg::LSMPC_NORMAL);
        lsmpc_host_inst.xfer({4'h3, 11'h001});
        repeat (6) @(negedge clk_sys);
        check(8'(exp_q.size()), 8'h00);
        check(8'(mode), 8'(lsmpc_pkg::LSMPC_NORMAL));
        check(8'(drv), 8'h0a);
        p.failsafe_config_pin = 1'b1;
        p.lamp_req[0] = 1'b1;
        expect_mode(lsmpc_pkg::LSMPC_FAILSAFE);
        p.failsafe_config_pin = 1'b0;
        expect_mode(lsmpc_pkg::LSMPC_NORMAL);
        p.wake = 1'b0;
        p.lamp_req = 4'h0;
        expect_mode(lsmpc_pkg::LSMPC_SLEEP);
        check(8'(drv), 8'h00);
        tally_and_finish;
    end
endmodule
